// file: core/fault_pair_bank.sv
// Sticky fault flags for one register: eight status/clear pairs
`timescale 1ns/10ps
module fault_pair_bank #(
  parameter int unsigned pairs = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [pairs-1:0] detect,
  input wire logic wr_en,
  input wire logic [2*pairs-1:0] wr_data,
  output logic [pairs-1:0] flags
);
  import fault_regs_pkg::*;

  // Elaboration check: the register word holds exactly eight pairs
  if (pairs != pair_n) begin : g_pairs_check
    $error("fault_pair_bank: pairs must be %0d", pair_n);
  end

  logic [pairs-1:0] flags_ff;
  logic [pairs-1:0] nxt_flags;

  // Clear needs both bits of the pair high in one write; detection wins
  always_comb begin
    nxt_flags = flags_ff;
    for (int k = 0; k < pairs; k++) begin
      if (wr_en && wr_data[2*k+1] && wr_data[2*k]) begin
        nxt_flags[k] = 1'b0;
      end
      if (detect[k]) begin
        nxt_flags[k] = 1'b1;
      end
    end
  end

  // Flags reset clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= pairs_reset;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;
endmodule

// file: core/fault_regs_pkg.sv
// Package: offsets, field positions and reset values of the fault status registers
package fault_regs_pkg;
  localparam int unsigned addr_w = 8;
  localparam int unsigned data_w = 16;
  localparam int unsigned pair_n = 8;
  localparam logic [7:0] supply_fault_flags_off = 8'h0e;
  localparam logic [7:0] boost_fault_flags_off = 8'h10;
  localparam logic [15:0] flags_reset = 16'h0000;
  localparam logic [7:0] pairs_reset = 8'h00;
  // Pair index k: status bit 2k+1, clear bit 2k
  localparam int unsigned cfg_check_fail_pair = 7;
  localparam int unsigned ext_sync_lost_pair = 6;
  localparam int unsigned pump_fault_pair = 5;
  localparam int unsigned pump_cap_absent_pair = 4;
  localparam int unsigned input_overcurrent_pair = 3;
  localparam int unsigned core_undervolt_pair = 2;
  localparam int unsigned input_overvolt_pair = 1;
  localparam int unsigned input_undervolt_pair = 0;
  localparam int unsigned thermal_trip_pair = 7;
  localparam int unsigned boost_low_overvolt_pair = 0;
  // Boost pairs that feed the interrupt pin; the low over-voltage pair does not
  localparam logic [7:0] boost_pin_mask = 8'hfe;
  localparam logic [7:0] supply_pin_mask = 8'hff;
endpackage

// file: core/fault_status_clear_regs.sv
// Fault status register bank: supply and boost sticky flags with paired clears
//
// Function
// - Supply fault register at 0Eh, resets zero
// - Boost fault register at 10h, resets zero
// - Status bit reads one when fault seen
// - Clear needs status and clear bits together
// - Valid clear without same-cycle detection drops flag and pin contribution
// - Supply bit 15 config check, 14 clear
// - Supply bit 13 sync lost, 12 clear
// - Supply bit 11 pump fault, 10 clear
// - Supply bit 9 pump cap, 8 clear
// - Supply bit 7 input overcurrent, 6 clear
// - Supply bit 5 core undervolt, 4 clear
// - Supply bit 3 input overvolt, 2 clear
// - Supply bit 1 input undervolt, 0 clear
// - Boost bit 15 thermal trip, paired clear
// - Boost low overvolt clear skips pin
`timescale 1ns/10ps
module fault_status_clear_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [fault_regs_pkg::pair_n-1:0] supply_detect,
  input wire logic [fault_regs_pkg::pair_n-1:0] boost_detect,
  input wire logic reg_wr,
  input wire logic [fault_regs_pkg::addr_w-1:0] reg_addr,
  input wire logic [fault_regs_pkg::data_w-1:0] reg_wdata,
  output logic [fault_regs_pkg::data_w-1:0] reg_rdata,
  output logic fault_int_n
);
  import fault_regs_pkg::*;

  logic [pair_n-1:0] supply_flags;
  logic [pair_n-1:0] boost_flags;
  logic supply_wr;
  logic boost_wr;
  logic [data_w-1:0] supply_view;
  logic [data_w-1:0] boost_view;
  logic [data_w-1:0] nxt_rdata;
  logic [data_w-1:0] rdata_ff;
  logic nxt_int_n;
  logic int_n_ff;
  // Named fault views, read by the checks at the bottom
  logic cfg_check_fail_flag;
  logic ext_sync_lost_flag;
  logic pump_fault_flag;
  logic pump_cap_absent_flag;
  logic input_overcurrent_flag;
  logic core_undervolt_flag;
  logic input_overvolt_flag;
  logic input_undervolt_flag;
  logic thermal_trip_flag;
  logic boost_low_overvolt_flag;
  // Valid clear requests: both bits of a pair in one write
  logic cfg_check_fail_ack;
  logic ext_sync_lost_ack;
  logic pump_fault_ack;
  logic pump_cap_absent_ack;
  logic input_overcurrent_ack;
  logic core_undervolt_ack;
  logic input_overvolt_ack;
  logic input_undervolt_ack;
  logic thermal_trip_ack;
  logic boost_low_overvolt_ack;

  // Address decode of the two register words
  assign supply_wr = reg_wr && (reg_addr == supply_fault_flags_off);
  assign boost_wr = reg_wr && (reg_addr == boost_fault_flags_off);

  // Named views of the stored flags
  assign cfg_check_fail_flag = supply_flags[cfg_check_fail_pair];
  assign ext_sync_lost_flag = supply_flags[ext_sync_lost_pair];
  assign pump_fault_flag = supply_flags[pump_fault_pair];
  assign pump_cap_absent_flag = supply_flags[pump_cap_absent_pair];
  assign input_overcurrent_flag = supply_flags[input_overcurrent_pair];
  assign core_undervolt_flag = supply_flags[core_undervolt_pair];
  assign input_overvolt_flag = supply_flags[input_overvolt_pair];
  assign input_undervolt_flag = supply_flags[input_undervolt_pair];
  assign thermal_trip_flag = boost_flags[thermal_trip_pair];
  assign boost_low_overvolt_flag = boost_flags[boost_low_overvolt_pair];

  // Clear requests with bit positions written out per field,
  // so a slip in the pair arithmetic shows up in the checks
  assign cfg_check_fail_ack = supply_wr && reg_wdata[15] && reg_wdata[14];
  assign ext_sync_lost_ack = supply_wr && reg_wdata[13] && reg_wdata[12];
  assign pump_fault_ack = supply_wr && reg_wdata[11] && reg_wdata[10];
  assign pump_cap_absent_ack = supply_wr && reg_wdata[9] && reg_wdata[8];
  assign input_overcurrent_ack = supply_wr && reg_wdata[7] && reg_wdata[6];
  assign core_undervolt_ack = supply_wr && reg_wdata[5] && reg_wdata[4];
  assign input_overvolt_ack = supply_wr && reg_wdata[3] && reg_wdata[2];
  assign input_undervolt_ack = supply_wr && reg_wdata[1] && reg_wdata[0];
  assign thermal_trip_ack = boost_wr && reg_wdata[15] && reg_wdata[14];
  assign boost_low_overvolt_ack = boost_wr && reg_wdata[1] && reg_wdata[0];

  // Supply pairs, bit order 15..0 follows the pair index
  fault_pair_bank #(.pairs(pair_n)) u_supply (
    .clock(clock),
    .arst_n(arst_n),
    .detect(supply_detect),
    .wr_en(supply_wr),
    .wr_data(reg_wdata),
    .flags(supply_flags)
  );

  // Boost pairs, thermal trip at the top pair
  fault_pair_bank #(.pairs(pair_n)) u_boost (
    .clock(clock),
    .arst_n(arst_n),
    .detect(boost_detect),
    .wr_en(boost_wr),
    .wr_data(reg_wdata),
    .flags(boost_flags)
  );

  // Status in odd bits, clear bits read back zero since they never store
  always_comb begin
    supply_view = flags_reset;
    boost_view = flags_reset;
    for (int k = 0; k < pair_n; k++) begin
      supply_view[2*k+1] = supply_flags[k];
      boost_view[2*k+1] = boost_flags[k];
    end
  end

  // Next values of the output registers; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      supply_fault_flags_off: nxt_rdata = supply_view;
      boost_fault_flags_off: nxt_rdata = boost_view;
      default: nxt_rdata = flags_reset;
    endcase
    // Pin low while any pin-enabled flag is set; low overvolt kept off the pin
    nxt_int_n = ~(|(supply_flags & supply_pin_mask) | |(boost_flags & boost_pin_mask));
  end

  // Output registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= flags_reset;
      int_n_ff <= 1'b1;
    end else begin
      rdata_ff <= nxt_rdata;
      int_n_ff <= nxt_int_n;
    end
  end

  assign reg_rdata = rdata_ff;
  assign fault_int_n = int_n_ff;

  // Checks
  a_set_sticks: assert property (@(posedge clock) disable iff (!arst_n)
    supply_detect[0] |=> supply_flags[0]) else $error("detected fault not recorded");
  a_half_write: assert property (@(posedge clock) disable iff (!arst_n)
    (supply_wr && !reg_wdata[0] && supply_flags[0]) |=> supply_flags[0]) else $error("half clear dropped flag");
  a_full_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (boost_wr && reg_wdata[15] && reg_wdata[14] && !boost_detect[7]) |=> !boost_flags[7])
    else $error("thermal clear ignored");
  a_pin_follow: assert property (@(posedge clock) disable iff (!arst_n)
    supply_flags[7] |=> !fault_int_n) else $error("pin not asserted");
  a_low_ovp_pin: assert property (@(posedge clock) disable iff (!arst_n)
    (boost_flags == 8'h01 && supply_flags == 8'h00) |=> fault_int_n) else $error("low overvolt drove pin");
  a_read_supply: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_addr == supply_fault_flags_off) |=> reg_rdata[15] == $past(supply_flags[7])) else $error("bad supply read");
  a_read_boost: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_addr == boost_fault_flags_off) |=> reg_rdata[1] == $past(boost_flags[0])) else $error("bad boost read");
  a_clear_bits_zero: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rdata[0] == 1'b0 && reg_rdata[14] == 1'b0) else $error("clear bit read high");

  // Per-fault clears; a detection in the same cycle is left out since it wins
  a_cfg_check_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (cfg_check_fail_ack && !supply_detect[cfg_check_fail_pair]) |=> !cfg_check_fail_flag)
    else $error("config check clear ignored");
  a_sync_lost_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (ext_sync_lost_ack && !supply_detect[ext_sync_lost_pair]) |=> !ext_sync_lost_flag)
    else $error("sync lost clear ignored");
  a_pump_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (pump_fault_ack && !supply_detect[pump_fault_pair]) |=> !pump_fault_flag)
    else $error("pump fault clear ignored");
  a_pump_cap_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (pump_cap_absent_ack && !supply_detect[pump_cap_absent_pair]) |=> !pump_cap_absent_flag)
    else $error("pump cap clear ignored");
  a_overcurrent_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (input_overcurrent_ack && !supply_detect[input_overcurrent_pair]) |=> !input_overcurrent_flag)
    else $error("overcurrent clear ignored");
  a_core_uv_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (core_undervolt_ack && !supply_detect[core_undervolt_pair]) |=> !core_undervolt_flag)
    else $error("core undervolt clear ignored");
  a_overvolt_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (input_overvolt_ack && !supply_detect[input_overvolt_pair]) |=> !input_overvolt_flag)
    else $error("input overvolt clear ignored");
  a_undervolt_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (input_undervolt_ack && !supply_detect[input_undervolt_pair]) |=> !input_undervolt_flag)
    else $error("input undervolt clear ignored");
  a_low_ovp_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (boost_low_overvolt_ack && !boost_detect[boost_low_overvolt_pair]) |=> !boost_low_overvolt_flag)
    else $error("low overvolt clear ignored");

  // Stored flags move only by detection or a valid clear; then the thermal read and the pin release
  a_flag_holds: assert property (@(posedge clock) disable iff (!arst_n)
    (thermal_trip_flag && !thermal_trip_ack) |=> thermal_trip_flag)
    else $error("thermal flag dropped without clear");
  a_write_no_set: assert property (@(posedge clock) disable iff (!arst_n)
    (!input_undervolt_flag && !supply_detect[input_undervolt_pair]) |=> !input_undervolt_flag)
    else $error("flag set without detection");
  a_thermal_read: assert property (@(posedge clock) disable iff (!arst_n)
    (reg_addr == boost_fault_flags_off) |=> reg_rdata[15] == $past(thermal_trip_flag))
    else $error("bad thermal read");
  a_pin_release: assert property (@(posedge clock) disable iff (!arst_n)
    (supply_flags == 8'h00 && boost_flags[7:1] == 7'h00) |=> fault_int_n)
    else $error("pin held without pin fault");

  // Main scenarios; the pin trails the flag by one register stage
  c_supply_clear: cover property (@(posedge clock) disable iff (!arst_n)
    supply_flags[3] ##1 !supply_flags[3]);
  c_thermal_set: cover property (@(posedge clock) disable iff (!arst_n)
    boost_detect[7] ##2 !fault_int_n);
  c_set_on_clear: cover property (@(posedge clock) disable iff (!arst_n)
    supply_wr && reg_wdata[1:0] == 2'h3 && supply_detect[0]);
  c_low_ovp_clear: cover property (@(posedge clock) disable iff (!arst_n)
    (boost_low_overvolt_flag && boost_low_overvolt_ack) ##1 !boost_low_overvolt_flag);
  c_pin_release: cover property (@(posedge clock) disable iff (!arst_n)
    !fault_int_n ##1 fault_int_n);
endmodule

// file: tb/test_fault_status_clear_regs.sv
// Self-checking bench for the supply and boost fault status registers
`timescale 1ns/10ps
module test_fault_status_clear_regs;
  import fault_regs_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic fault_int_n;
  logic [7:0] supply_detect = 8'h00;
  logic [7:0] boost_detect = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] rnd = 16'h956e;
  logic [7:0] sup_m = 8'h00;
  logic [7:0] bst_m = 8'h00;
  int n_errors = 0;
  int compares = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  fault_status_clear_regs fault_status_clear_regs_inst (.clock(clock), .arst_n(arst_n),
    .supply_detect(supply_detect), .boost_detect(boost_detect), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fault_int_n(fault_int_n));
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Read view: status at 2k+1, clear bits always read zero
  function automatic logic [15:0] view(logic [7:0] f);
    logic [15:0] v;
    v = 16'h0000;
    for (int k = 0; k < 8; k++) v[2*k+1] = f[k];
    return v;
  endfunction
  // Only pairs with both bits high are cleared
  function automatic logic [7:0] clr(logic [15:0] d);
    logic [7:0] c;
    for (int k = 0; k < 8; k++) c[k] = d[2*k+1] & d[2*k];
    return c;
  endfunction
  task automatic chk(string name, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  // Pin compare kept apart so a stuck pin is reported by name
  task automatic chk_pin(string name, logic e, logic g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %b seen %b", name, e, g);
    end
  endtask
  // Pin low while any flag but the boost low overvolt one is set
  function automatic logic pin_exp(logic [7:0] s, logic [7:0] b);
    return ~(|s | |b[7:1]);
  endfunction
  // Outputs while reset is held
  task automatic reset_chk();
    chk("reset rdata", flags_reset, reg_rdata);
    chk_pin("reset pin", 1'b1, fault_int_n);
  endtask
  // One cycle of stimulus; the model takes it at the next edge, set beats clear
  task automatic cyc(logic [7:0] sd, logic [7:0] bd, logic wr, logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    #1;
    supply_detect = sd;
    boost_detect = bd;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    if (wr && a == supply_fault_flags_off) sup_m = sup_m & ~clr(d);
    if (wr && a == boost_fault_flags_off) bst_m = bst_m & ~clr(d);
    sup_m = sup_m | sd;
    bst_m = bst_m | bd;
  endtask
  // Idle reads of both registers, an unmapped offset and the pin
  task automatic settle_chk();
    cyc(8'h00, 8'h00, 1'b0, supply_fault_flags_off, 16'h0000);
    cyc(8'h00, 8'h00, 1'b0, boost_fault_flags_off, 16'h0000);
    chk("supply", view(sup_m), reg_rdata);
    cyc(8'h00, 8'h00, 1'b0, 8'h0c, 16'h0000);
    chk("boost", view(bst_m), reg_rdata);
    cyc(8'h00, 8'h00, 1'b0, 8'h0c, 16'h0000);
    chk("unmapped", 16'h0000, reg_rdata);
    chk_pin("pin", pin_exp(sup_m, bst_m), fault_int_n);
  endtask
  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_chk();
    arst_n = 1'b1;
    settle_chk();
    // Each pair alone: status only, clear only, wrong offset, both, then set against clear
    for (int k = 0; k < 16; k++) begin
      logic [7:0] a;
      logic [7:0] one;
      logic [15:0] both;
      a = (k < 8) ? supply_fault_flags_off : boost_fault_flags_off;
      one = 8'h01 << (k % 8);
      both = 16'h0003 << (2 * (k % 8));
      cyc((k < 8) ? one : 8'h00, (k < 8) ? 8'h00 : one, 1'b0, a, 16'h0000);
      settle_chk();
      cyc(8'h00, 8'h00, 1'b1, a, both & 16'haaaa);
      cyc(8'h00, 8'h00, 1'b1, a, both & 16'h5555);
      cyc(8'h00, 8'h00, 1'b1, 8'h12, both);
      settle_chk();
      cyc(8'h00, 8'h00, 1'b1, a, both);
      settle_chk();
      // Detection in the cycle of a valid clear keeps the flag
      cyc((k < 8) ? one : 8'h00, (k < 8) ? 8'h00 : one, 1'b1, a, both);
      settle_chk();
      cyc(8'h00, 8'h00, 1'b1, a, both);
      settle_chk();
    end
    // Random detects and writes, back to back, checked every ten cycles
    for (int i = 0; i < 600; i++) begin
      logic [15:0] r2;
      rnd = lfsr(rnd);
      r2 = lfsr(lfsr(rnd));
      cyc(rnd[7:0] & r2[7:0] & rnd[15:8], rnd[15:8] & r2[15:8] & rnd[7:0], r2[0],
          r2[2] ? boost_fault_flags_off : (r2[1] ? supply_fault_flags_off : r2[15:8]), lfsr(r2));
      rnd = r2;
      if (i % 10 == 9) settle_chk();
    end
    // Reset in mid-run clears every flag; driven at the supply offset after every flag is set
    cyc(8'hff, 8'hff, 1'b0, supply_fault_flags_off, 16'h0000);
    cyc(8'h00, 8'h00, 1'b0, supply_fault_flags_off, 16'h0000);
    @(posedge clock);
    #1;
    arst_n = 1'b0;
    sup_m = 8'h00;
    bst_m = 8'h00;
    @(posedge clock);
    #1;
    reset_chk();
    arst_n = 1'b1;
    settle_chk();
    finish_test();
  end
endmodule
